// file: hw/scsi_consts.svh
// Named offsets, field positions, reset values and timing counts of the card interface.
`ifndef SCSI_CONSTS_SVH
`define SCSI_CONSTS_SVH

// ==========================================
// Register offsets, compared against the full address.
`define SCSI_OFF_MODE 32'hfffffe80
`define SCSI_OFF_BRATE 32'hfffffe82
`define SCSI_OFF_CTRL 32'hfffffe84
`define SCSI_OFF_TXDATA 32'h0ffffe86
`define SCSI_OFF_STATUS 32'hfffffe88
`define SCSI_OFF_RXDATA 32'h0ffffe8a
`define SCSI_OFF_CARD 32'hfffffe8c

// ==========================================
// Field positions.
`define SCSI_MODE_CTS 7
`define SCSI_MODE_ODD 4
`define SCSI_MODE_PRE_HI 1
`define SCSI_MODE_PRE_LO 0
`define SCSI_CTRL_TX_EN 5
`define SCSI_CTRL_RX_EN 4
`define SCSI_CTRL_IDLE 1
`define SCSI_CTRL_CKOE 0
`define SCSI_ST_TXEMPTY 7
`define SCSI_ST_RXFULL 6
`define SCSI_ST_OVERRUN 5
`define SCSI_ST_ERR_SIG 4
`define SCSI_ST_PAR_ERR 3
`define SCSI_ST_DONE 2
`define SCSI_CARD_MSB 3
`define SCSI_CARD_INV 2
`define SCSI_CARD_EN 0

// ==========================================
// Reset values and write masks.
`define SCSI_RST_MODE 8'h00
`define SCSI_RST_BRATE 8'h00
`define SCSI_RST_CTRL 8'h00
`define SCSI_RST_DATA 8'h00
`define SCSI_CARD_WMASK 8'h0d
`define SCSI_PORT_MODE_OUT 2'h1

// ==========================================
// Timing, in base clocks and elementary time units from the start bit.
`define SCSI_ETU_BASE_CLKS 372
`define SCSI_TICK_LAST (9'(`SCSI_ETU_BASE_CLKS - 1))
`define SCSI_TICK_SAMPLE (9'(186 - 1))
`define SCSI_TICK_HALF (9'(`SCSI_ETU_BASE_CLKS / 2))
`define SCSI_ETU_START 4'h0
`define SCSI_ETU_D7 4'h8
`define SCSI_ETU_PARITY 4'h9
`define SCSI_ETU_ERR 4'ha
`define SCSI_ETU_ERR_END 4'hb
`define SCSI_ETU_DONE_CTS 4'ha
`define SCSI_ETU_LAST 4'hc

`endif

// file: hw/scsi_pkg.sv
// Types shared by the card interface: configuration view and state encodings.
package scsi_pkg;

	// ==========================================
	// Decoded configuration fields taken from the control registers.
	typedef struct packed {
		logic clock_transmit_done_flag_select;
		logic parity_odd_select;
		logic [1:0] prescale_select;
		logic transmit_enable;
		logic receive_enable;
		logic idle_clock_level;
		logic clock_output_enable;
		logic bit_order_msb_first;
		logic data_invert;
		logic card_mode_enable;
	} scsi_cfg_t;

	// Transmitter states, Gray coded along the path.
	typedef enum logic [1:0] {
		SCSI_TX_IDLE = 2'h0,
		SCSI_TX_FRAME = 2'h1
	} scsi_tx_state_t;

	// Receiver states, Gray coded along the path.
	typedef enum logic [1:0] {
		SCSI_RX_IDLE = 2'h0,
		SCSI_RX_FRAME = 2'h1,
		SCSI_RX_ERROR = 2'h3
	} scsi_rx_state_t;

endpackage : scsi_pkg

// file: hw/scsi_card_if.sv
// Half-duplex smart card serial interface: registers, baud generator, transmitter, receiver.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`include "scsi_consts.svh"

// How it works
// - Start bit, eight data bits, one parity.
// - At least two etu guard between frames.
// - Parity error: line low 10.5 to 11.5.
// - Error sampled: resend same character after 2 etu.
// - Only asynchronous start-stop framing supported.
// - Both enables: own transmission is received.
// - Transmitter releases line when idle, after parity.
// - Receiver releases line after error signal.
// - Done-time select picks flag timing, clock state.
// - Inversion touches data bits, never parity.
// - Direct: high is one, LSB first.
// - Inverse: low is one, MSB first.
// - Clock comes only from internal generator.
// - Bit rate from divisor and prescale select.
// - Card clock runs at 372 times bit rate.
// - Stopped clock: port pin or fixed level.
// - Clock pin starts only on a rising and stops on a falling base clock edge, or at once when card mode is cleared.
// - No partial clock periods on the pin while card mode stays enabled.
// - Done flag at 2.5 or 1.0 etu.
// - Low sampled error signal sets error flag.
// - Bit order selects MSB or LSB first.
// - Start edge on base clock, sample at 186.
module scsi_card_if
	import scsi_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int DIV_W = 8
) (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_standby,
	// Register port.
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Shared open-drain data line.
	input wire logic i_data_line,
	output logic o_data_line_out,
	output logic o_data_line_oe,
	// Card clock pin and its port fallback.
	input wire logic [1:0] i_port_mode_bits,
	input wire logic i_port_level,
	output logic o_card_clk,
	output logic o_card_clk_oe
);

	// ==========================================
	// Elaboration checks.
	generate
		if (ADDR_W < 32 || DIV_W != 8) begin : g_bad_param
			$error("Address must be at least 32 bits and divisor 8 bits.");
		end
	endgenerate

	// ==========================================
	// Declarations.
	logic rst; // Chip reset or standby.
	logic [7:0] serial_mode_reg; // Mode bits.
	logic [DIV_W-1:0] bit_rate_reg; // Divisor N.
	logic [7:0] serial_control_reg; // Enables and clock select.
	logic [7:0] transmit_data_reg; // Character to send.
	logic [7:0] receive_data_reg; // Last character received.
	logic [7:0] card_mode_reg; // Order, inversion, card mode.
	logic tx_empty_reg; // Transmit data taken.
	logic rx_full_reg; // Receive data waiting.
	logic overrun_reg; // Character lost.
	logic error_signal_flag_reg; // Card returned an error signal.
	logic parity_error_flag_reg; // Received parity wrong.
	logic transmit_done_flag_reg; // Transmission ended.
	logic [7:0] rdata_reg; // Read answer.
	scsi_cfg_t cfg; // Decoded configuration.
	logic [DIV_W+6:0] presc_cnt_reg; // Prescaler count.
	logic [DIV_W+6:0] presc_limit; // Prescaler terminal count.
	logic phase_reg; // Base clock phase, also the card clock.
	logic half_tick; // Base clock half period ends.
	logic base_tick; // One pulse per base clock.
	logic sck_run_reg; // Card clock running on the pin.
	logic sck_run_next; // Next run state.
	logic card_clk_reg; // Pin level.
	logic card_clk_oe_reg; // Pin enable.
	logic sync1_reg; // Data line synchroniser, first stage.
	logic sync2_reg; // Second stage.
	logic sync3_reg; // Third stage.
	logic line_reg; // Filtered line level.
	logic line_fall; // Start edge seen.
	scsi_tx_state_t tx_state_reg; // Transmitter state.
	logic [8:0] tx_tick_reg; // Base clocks within etu.
	logic [3:0] tx_etu_reg; // Etu within frame.
	logic [7:0] tx_char_reg; // Line-order data bits.
	logic tx_par_reg; // Parity bit to send.
	logic tx_err_seen_reg; // Error signal in this frame.
	logic tx_drive; // Transmitter pulls line low.
	logic tx_step; // Transmitter base clock step.
	logic tx_etu_end; // Last base clock of an etu.
	scsi_rx_state_t rx_state_reg; // Receiver state.
	logic [8:0] rx_tick_reg; // Base clocks within etu.
	logic [3:0] rx_etu_reg; // Etu within frame.
	logic [7:0] rx_shift_reg; // Bits in line order.
	logic rx_err_drive_reg; // Receiver pulls line low.
	logic data_oe_reg; // Line enable.
	logic rx_par_bad; // Parity check outcome.
	logic st_wr; // Status write this cycle.

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n || i_standby);

	// ==========================================
	// Functions.

	// Bit order and inversion; the same map serves both directions.
	function automatic logic [7:0] scsi_conv(input logic [7:0] d, input logic msb,
		input logic inv);
		logic [7:0] r;
		r = d;
		if (msb) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = d[7-i];
			end
		end
		return r ^ {8{inv}};
	endfunction : scsi_conv

	// ==========================================
	// Configuration and register port.
	assign rst = !i_reset_n || i_standby;
	assign st_wr = i_wr && (i_addr == `SCSI_OFF_STATUS);

	// Field view of the control registers.
	always_comb begin
		cfg.clock_transmit_done_flag_select = serial_mode_reg[`SCSI_MODE_CTS];
		cfg.parity_odd_select = serial_mode_reg[`SCSI_MODE_ODD];
		cfg.prescale_select = serial_mode_reg[`SCSI_MODE_PRE_HI:`SCSI_MODE_PRE_LO];
		cfg.transmit_enable = serial_control_reg[`SCSI_CTRL_TX_EN];
		cfg.receive_enable = serial_control_reg[`SCSI_CTRL_RX_EN];
		cfg.idle_clock_level = serial_control_reg[`SCSI_CTRL_IDLE];
		cfg.clock_output_enable = serial_control_reg[`SCSI_CTRL_CKOE];
		cfg.bit_order_msb_first = card_mode_reg[`SCSI_CARD_MSB];
		cfg.data_invert = card_mode_reg[`SCSI_CARD_INV];
		cfg.card_mode_enable = card_mode_reg[`SCSI_CARD_EN];
	end

	// Plain writable registers.
	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			serial_mode_reg <= `SCSI_RST_MODE;
			bit_rate_reg <= `SCSI_RST_BRATE;
			serial_control_reg <= `SCSI_RST_CTRL;
			transmit_data_reg <= `SCSI_RST_DATA;
			card_mode_reg <= `SCSI_RST_DATA;
		end else if (i_wr) begin
			if (i_addr == `SCSI_OFF_MODE) begin
				serial_mode_reg <= i_wdata;
			end else if (i_addr == `SCSI_OFF_BRATE) begin
				bit_rate_reg <= i_wdata;
			end else if (i_addr == `SCSI_OFF_CTRL) begin
				serial_control_reg <= i_wdata;
			end else if (i_addr == `SCSI_OFF_TXDATA) begin
				transmit_data_reg <= i_wdata;
			end else if (i_addr == `SCSI_OFF_CARD) begin
				card_mode_reg <= i_wdata & `SCSI_CARD_WMASK;
			end
		end
	end

	// Read answer stands only in the cycle after the read strobe.
	always_ff @(posedge i_core_clk) begin
		if (rst || !i_rd) begin
			rdata_reg <= 8'h00;
		end else if (i_addr == `SCSI_OFF_MODE) begin
			rdata_reg <= serial_mode_reg;
		end else if (i_addr == `SCSI_OFF_BRATE) begin
			rdata_reg <= bit_rate_reg;
		end else if (i_addr == `SCSI_OFF_CTRL) begin
			rdata_reg <= serial_control_reg;
		end else if (i_addr == `SCSI_OFF_TXDATA) begin
			rdata_reg <= transmit_data_reg;
		end else if (i_addr == `SCSI_OFF_STATUS) begin
			rdata_reg <= {tx_empty_reg, rx_full_reg, overrun_reg, error_signal_flag_reg,
				parity_error_flag_reg, transmit_done_flag_reg, 2'h0};
		end else if (i_addr == `SCSI_OFF_RXDATA) begin
			rdata_reg <= receive_data_reg;
		end else if (i_addr == `SCSI_OFF_CARD) begin
			rdata_reg <= card_mode_reg;
		end else begin
			rdata_reg <= 8'h00; // Unmapped addresses read zero.
		end
	end

	// ==========================================
	// Baud generator: half period of the base clock is 4^n*(N+1) core clocks.
	// The shift is bracketed so that it is done before the subtraction.
	assign presc_limit = (((DIV_W+7)'(bit_rate_reg) + (DIV_W+7)'(1))
		<< {cfg.prescale_select, 1'b0}) - (DIV_W+7)'(1);
	assign half_tick = (presc_cnt_reg == presc_limit);
	assign base_tick = half_tick && phase_reg;

	// Prescaler and base clock phase.
	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			presc_cnt_reg <= '0;
			phase_reg <= 1'b0;
		end else if (half_tick) begin
			presc_cnt_reg <= '0;
			phase_reg <= ~phase_reg;
		end else begin
			presc_cnt_reg <= presc_cnt_reg + (DIV_W+7)'(1);
		end
	end

	// Clock starts only at a rising phase; it stops at a falling one, or at once when card mode is cleared.
	always_comb begin
		sck_run_next = sck_run_reg;
		if (half_tick && !phase_reg && cfg.clock_output_enable) begin
			sck_run_next = 1'b1;
		end else if (half_tick && phase_reg && !cfg.clock_output_enable) begin
			sck_run_next = 1'b0;
		end
	end

	// Card clock pin: running clock, fixed level, or port pin.
	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			sck_run_reg <= 1'b0;
			card_clk_reg <= 1'b0;
			card_clk_oe_reg <= 1'b0;
		end else begin
			sck_run_reg <= sck_run_next && cfg.card_mode_enable;
			if (cfg.card_mode_enable && sck_run_next) begin
				card_clk_reg <= half_tick ? ~phase_reg : phase_reg;
				card_clk_oe_reg <= 1'b1;
			end else if (cfg.card_mode_enable && cfg.clock_transmit_done_flag_select) begin
				card_clk_reg <= cfg.idle_clock_level;
				card_clk_oe_reg <= 1'b1;
			end else begin
				card_clk_reg <= i_port_level;
				card_clk_oe_reg <= (i_port_mode_bits == `SCSI_PORT_MODE_OUT);
			end
		end
	end

	// ==========================================
	// Data line input: three-stage synchroniser and agreement filter.
	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			sync3_reg <= 1'b1;
			line_reg <= 1'b1;
		end else begin
			sync1_reg <= i_data_line;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			if (sync2_reg == sync3_reg) begin
				line_reg <= sync2_reg;
			end
		end
	end
	assign line_fall = line_reg && !sync2_reg && !sync3_reg;

	// ==========================================
	// Transmitter.
	assign tx_step = base_tick && (tx_state_reg == SCSI_TX_FRAME);
	assign tx_etu_end = (tx_tick_reg == `SCSI_TICK_LAST);

	// Line is pulled low only for zero bits of start, data and parity.
	always_comb begin
		tx_drive = 1'b0;
		if (tx_state_reg == SCSI_TX_FRAME) begin
			if (tx_etu_reg == `SCSI_ETU_START) begin
				tx_drive = 1'b1;
			end else if (tx_etu_reg <= `SCSI_ETU_D7) begin
				tx_drive = ~tx_char_reg[3'(tx_etu_reg - 4'h1)];
			end else if (tx_etu_reg == `SCSI_ETU_PARITY) begin
				tx_drive = ~tx_par_reg;
			end
		end
	end

	// Frame sequencer: 13 etu per frame, then idle or resend.
	always_ff @(posedge i_core_clk) begin
		if (rst || !cfg.transmit_enable || !cfg.card_mode_enable) begin
			tx_state_reg <= SCSI_TX_IDLE;
			tx_tick_reg <= '0;
			tx_etu_reg <= '0;
			tx_char_reg <= '0;
			tx_par_reg <= 1'b0;
			tx_err_seen_reg <= 1'b0;
		end else begin
			case (tx_state_reg)
				SCSI_TX_IDLE: begin
					if (!tx_empty_reg) begin
						tx_char_reg <= scsi_conv(transmit_data_reg, cfg.bit_order_msb_first,
							cfg.data_invert);
						tx_par_reg <= ^scsi_conv(transmit_data_reg, cfg.bit_order_msb_first,
							cfg.data_invert) ^ cfg.parity_odd_select;
						tx_tick_reg <= '0;
						tx_etu_reg <= '0;
						tx_err_seen_reg <= 1'b0;
						tx_state_reg <= SCSI_TX_FRAME;
					end
				end
				SCSI_TX_FRAME: begin
					if (tx_step) begin
						tx_tick_reg <= tx_etu_end ? '0 : tx_tick_reg + 9'h1;
						if (tx_etu_end) begin
							tx_etu_reg <= tx_etu_reg + 4'h1;
						end
						// Error window sampled at 11.0 etu.
						if (tx_etu_end && tx_etu_reg == `SCSI_ETU_ERR && !line_reg) begin
							tx_err_seen_reg <= 1'b1;
						end
						if (tx_etu_end && tx_etu_reg == `SCSI_ETU_LAST) begin
							tx_etu_reg <= '0;
							tx_err_seen_reg <= 1'b0;
							if (!tx_err_seen_reg) begin
								tx_state_reg <= SCSI_TX_IDLE;
							end // Resend keeps the same character.
						end
					end
				end
				default: begin
					tx_state_reg <= SCSI_TX_IDLE;
				end
			endcase
		end
	end

	// Transmit empty: set on load, cleared by writing zero.
	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			tx_empty_reg <= 1'b1;
		end else if (tx_state_reg == SCSI_TX_IDLE && cfg.transmit_enable &&
			cfg.card_mode_enable && !tx_empty_reg) begin
			tx_empty_reg <= 1'b1;
		end else if (st_wr && !i_wdata[`SCSI_ST_TXEMPTY]) begin
			tx_empty_reg <= 1'b0;
		end
	end

	// Error signal flag and transmit done flag; a set wins over a clear.
	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			error_signal_flag_reg <= 1'b0;
			transmit_done_flag_reg <= 1'b1;
		end else begin
			if (tx_step && tx_etu_end && tx_etu_reg == `SCSI_ETU_ERR && !line_reg) begin
				error_signal_flag_reg <= 1'b1;
			end else if (st_wr && !i_wdata[`SCSI_ST_ERR_SIG]) begin
				error_signal_flag_reg <= 1'b0;
			end
			if ((!cfg.transmit_enable && !error_signal_flag_reg) ||
				(tx_step && tx_empty_reg && !error_signal_flag_reg && !tx_err_seen_reg &&
				(cfg.clock_transmit_done_flag_select ?
				(tx_etu_end && tx_etu_reg == `SCSI_ETU_DONE_CTS) :
				(tx_tick_reg == `SCSI_TICK_SAMPLE && tx_etu_reg == `SCSI_ETU_LAST)))) begin
				transmit_done_flag_reg <= 1'b1;
			end else if (st_wr && !i_wdata[`SCSI_ST_TXEMPTY]) begin
				transmit_done_flag_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Receiver.
	assign rx_par_bad = (^rx_shift_reg ^ line_reg) != cfg.parity_odd_select;

	// Receive sequencer: sample at the 186th base clock of each etu.
	always_ff @(posedge i_core_clk) begin
		if (rst || !cfg.receive_enable || !cfg.card_mode_enable) begin
			rx_state_reg <= SCSI_RX_IDLE;
			rx_tick_reg <= '0;
			rx_etu_reg <= '0;
			rx_shift_reg <= '0;
			rx_err_drive_reg <= 1'b0;
		end else begin
			case (rx_state_reg)
				SCSI_RX_IDLE: begin
					rx_tick_reg <= '0;
					rx_etu_reg <= '0;
					if (line_fall) begin
						rx_state_reg <= SCSI_RX_FRAME;
					end
				end
				SCSI_RX_FRAME, SCSI_RX_ERROR: begin
					if (base_tick) begin
						rx_tick_reg <= (rx_tick_reg == `SCSI_TICK_LAST) ? '0 : rx_tick_reg + 9'h1;
						if (rx_tick_reg == `SCSI_TICK_LAST) begin
							rx_etu_reg <= rx_etu_reg + 4'h1;
						end
						if (rx_tick_reg == `SCSI_TICK_SAMPLE) begin
							if (rx_state_reg == SCSI_RX_ERROR) begin
								if (rx_etu_reg == `SCSI_ETU_ERR) begin
									rx_err_drive_reg <= 1'b1;
								end else if (rx_etu_reg == `SCSI_ETU_ERR_END) begin
									rx_err_drive_reg <= 1'b0;
									rx_state_reg <= SCSI_RX_IDLE;
								end
							end else if (rx_etu_reg == `SCSI_ETU_START) begin
								if (line_reg) begin
									rx_state_reg <= SCSI_RX_IDLE; // False start.
								end
							end else if (rx_etu_reg <= `SCSI_ETU_D7) begin
								rx_shift_reg[3'(rx_etu_reg - 4'h1)] <= line_reg;
							end else begin
								rx_state_reg <= rx_par_bad ? SCSI_RX_ERROR : SCSI_RX_IDLE;
							end
						end
					end
				end
				default: begin
					rx_state_reg <= SCSI_RX_IDLE;
				end
			endcase
		end
	end

	// Receive data and flags at the parity sample; a set wins over a clear.
	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			receive_data_reg <= `SCSI_RST_DATA;
			rx_full_reg <= 1'b0;
			overrun_reg <= 1'b0;
			parity_error_flag_reg <= 1'b0;
		end else if (base_tick && rx_state_reg == SCSI_RX_FRAME &&
			rx_tick_reg == `SCSI_TICK_SAMPLE && rx_etu_reg == `SCSI_ETU_PARITY) begin
			if (rx_par_bad || !rx_full_reg) begin
				receive_data_reg <= scsi_conv(rx_shift_reg, cfg.bit_order_msb_first,
					cfg.data_invert);
			end
			rx_full_reg <= rx_full_reg || !rx_par_bad;
			overrun_reg <= overrun_reg || (rx_full_reg && !rx_par_bad);
			parity_error_flag_reg <= parity_error_flag_reg || rx_par_bad;
		end else if (st_wr) begin
			rx_full_reg <= rx_full_reg && i_wdata[`SCSI_ST_RXFULL];
			overrun_reg <= overrun_reg && i_wdata[`SCSI_ST_OVERRUN];
			parity_error_flag_reg <= parity_error_flag_reg && i_wdata[`SCSI_ST_PAR_ERR];
		end
	end

	// ==========================================
	// Pin outputs: the line is only ever pulled low.
	always_ff @(posedge i_core_clk) begin
		if (rst) begin
			data_oe_reg <= 1'b0;
		end else begin
			data_oe_reg <= tx_drive || rx_err_drive_reg;
		end
	end

	assign o_data_line_out = 1'b0;
	assign o_data_line_oe = data_oe_reg;
	assign o_card_clk = card_clk_reg;
	assign o_card_clk_oe = card_clk_oe_reg;
	assign o_rdata = rdata_reg;

	// ==========================================
	// Assertions.
	sequence tx_err_sample_s;
		tx_step && tx_etu_end && tx_etu_reg == `SCSI_ETU_ERR;
	endsequence
	sequence tx_frame_end_s;
		tx_step && tx_etu_end && tx_etu_reg == `SCSI_ETU_LAST;
	endsequence

	start_bit_low_a: assert property ($rose(tx_state_reg == SCSI_TX_FRAME) |=>
		o_data_line_oe) else $error("Start bit not driven low.");
	guard_release_a: assert property (tx_state_reg == SCSI_TX_FRAME &&
		tx_etu_reg > `SCSI_ETU_PARITY |-> !tx_drive) else $error("Line driven in guard time.");
	err_window_a: assert property (rx_state_reg == SCSI_RX_ERROR |->
		rx_err_drive_reg == ((rx_etu_reg == `SCSI_ETU_ERR && rx_tick_reg >= `SCSI_TICK_HALF) ||
		(rx_etu_reg == `SCSI_ETU_ERR_END && rx_tick_reg < `SCSI_TICK_HALF)))
		else $error("Error signal outside its window.");
	resend_a: assert property (tx_frame_end_s and tx_err_seen_reg |=>
		tx_state_reg == SCSI_TX_FRAME && tx_etu_reg == 4'h0 && tx_tick_reg == 9'h0)
		else $error("Character not resent after error.");
	card_only_a: assert property ($rose(tx_state_reg == SCSI_TX_FRAME) |->
		$past(cfg.card_mode_enable)) else $error("Frame outside card mode.");
	idle_release_a: assert property ((tx_state_reg == SCSI_TX_IDLE &&
		!rx_err_drive_reg) [*2] |-> !o_data_line_oe) else $error("Line driven while idle.");
	done_time_a: assert property ($rose(transmit_done_flag_reg) &&
		tx_state_reg == SCSI_TX_FRAME |-> (cfg.clock_transmit_done_flag_select ?
		(tx_etu_reg == `SCSI_ETU_DONE_CTS + 4'h1 && tx_tick_reg == 9'h0) :
		(tx_etu_reg == `SCSI_ETU_LAST && tx_tick_reg == `SCSI_TICK_HALF)))
		else $error("Done flag at wrong time.");
	err_flag_set_a: assert property (tx_err_sample_s and !line_reg |=>
		error_signal_flag_reg && tx_err_seen_reg) else $error("Error signal not flagged.");
	clk_whole_a: assert property ($changed(sck_run_reg) && cfg.card_mode_enable
		&& $past(cfg.card_mode_enable) |-> $past(half_tick)) else $error("Clock cut mid-period.");

endmodule : scsi_card_if

// file: tb/scsi_card_model.sv
// Behavioural IC card that shares the pulled-up data line with the device.
`timescale 1ns/100ps
module scsi_card_model #(
	parameter int ETU = 744
) (
	// Clock and the device side of the line.
	input wire logic i_clk,
	input wire logic i_oe,
	input wire logic i_out,
	output logic o_line
);
	logic drv_reg = 1'b0; // High while the card pulls the line low.
	// The pull-up wins whenever nobody drives low.
	assign o_line = !((i_oe && !i_out) || drv_reg);
	// Samples eight data bits and parity mid-bit, then may signal an error.
	task automatic recv(output logic [8:0] b, input logic err);
		@(negedge o_line);
		repeat (ETU / 2) @(posedge i_clk);
		for (int k = 0; k < 9; k++) begin
			repeat (ETU) @(posedge i_clk);
			b[k] = o_line;
		end
		repeat (ETU) @(posedge i_clk);
		if (err) begin
			drv_reg <= 1'b1;
			repeat (ETU) @(posedge i_clk);
			drv_reg <= 1'b0;
		end
	endtask : recv
	// Sends a start bit, then nine line levels, and releases the line.
	task automatic send(input logic [8:0] b);
		@(posedge i_clk);
		drv_reg <= 1'b1;
		for (int k = 0; k < 9; k++) begin
			repeat (ETU) @(posedge i_clk);
			drv_reg <= !b[k];
		end
		repeat (ETU) @(posedge i_clk);
		drv_reg <= 1'b0;
	endtask : send
endmodule : scsi_card_model

// file: tb/tb_top.sv
// Register-level testbench of the card interface against a behavioural card.
`timescale 1ns/100ps
`include "scsi_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	localparam int ETU = 744; // One etu at divisor 0, prescale 0.
	logic i_core_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [31:0] i_addr = 32'h0;
	logic [7:0] i_wdata = 8'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic o_oe;
	logic o_out;
	logic o_card_clk;
	logic o_card_clk_oe;
	logic [1:0] port_mode = 2'h1; // Port setting for the card clock pin.
	logic port_lvl = 1'b1; // Level the port would drive.
	logic line;
	logic [8:0] b;
	logic [7:0] v;
	int errors = 0;
	int checked = 0;
	always #5 i_core_clk = ~i_core_clk;
	scsi_card_if scsi_card_if_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_standby(1'b0), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_data_line(line), .o_data_line_out(o_out),
		.o_data_line_oe(o_oe), .i_port_mode_bits(port_mode), .i_port_level(port_lvl),
		.o_card_clk(o_card_clk), .o_card_clk_oe(o_card_clk_oe));
	scsi_card_model #(.ETU(ETU)) scsi_card_model_inst (.i_clk(i_core_clk), .i_oe(o_oe),
		.i_out(o_out), .o_line(line));
	// One-cycle write strobe.
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr
	// One-cycle read strobe; data are taken in the following cycle.
	task automatic rd(input logic [31:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd
	// Prints the counts and the verdict, then stops.
	task automatic finish_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	// Watchdog well beyond the roughly 47,000 cycles of the run.
	initial begin
		#700000;
		errors++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		rd(`SCSI_OFF_STATUS, v);
		`CHK(v, 8'h84)
		`CHK(o_card_clk, 1'b1)
		`CHK(o_card_clk_oe, 1'b1)
		rd(32'h12345678, v);
		`CHK(v, 8'h00)
		wr(`SCSI_OFF_MODE, 8'h28);
		wr(`SCSI_OFF_CARD, 8'h01);
		wr(`SCSI_OFF_CTRL, 8'h20);
		// Direct convention, even parity: 3b goes LSB first with parity 1.
		wr(`SCSI_OFF_TXDATA, 8'h3b);
		wr(`SCSI_OFF_STATUS, 8'h7c);
		scsi_card_model_inst.recv(b, 1'b0);
		`CHK(b, 9'h13b)
		`CHK(o_oe, 1'b0)
		rd(`SCSI_OFF_STATUS, v);
		`CHK(v[2], 1'b0)
		repeat (2 * ETU) @(posedge i_core_clk);
		rd(`SCSI_OFF_STATUS, v);
		`CHK(v[2], 1'b1)
		// Inverse convention with odd parity; the card rejects the first copy.
		wr(`SCSI_OFF_MODE, 8'h38);
		wr(`SCSI_OFF_CARD, 8'h0d);
		wr(`SCSI_OFF_TXDATA, 8'h3f);
		wr(`SCSI_OFF_STATUS, 8'h7c);
		scsi_card_model_inst.recv(b, 1'b1);
		`CHK(b, 9'h103)
		scsi_card_model_inst.recv(b, 1'b0);
		`CHK(b, 9'h103)
		rd(`SCSI_OFF_STATUS, v);
		`CHK(v[4], 1'b1)
		// Receive a5 with wrong parity in direct convention.
		wr(`SCSI_OFF_CTRL, 8'h10);
		wr(`SCSI_OFF_MODE, 8'h28);
		wr(`SCSI_OFF_CARD, 8'h01);
		repeat (ETU) @(posedge i_core_clk);
		scsi_card_model_inst.send(9'h1a5);
		repeat (ETU * 3 / 4) @(posedge i_core_clk);
		`CHK(o_oe, 1'b1)
		repeat (ETU) @(posedge i_core_clk);
		`CHK(o_oe, 1'b0)
		rd(`SCSI_OFF_RXDATA, v);
		`CHK(v, 8'ha5)
		rd(`SCSI_OFF_STATUS, v);
		`CHK(v[3], 1'b1)
		// Self loop with no card: both enables, error flags cleared, 5a comes back.
		wr(`SCSI_OFF_CTRL, 8'h30);
		wr(`SCSI_OFF_TXDATA, 8'h5a);
		wr(`SCSI_OFF_STATUS, 8'h64);
		repeat (14 * ETU) @(posedge i_core_clk);
		rd(`SCSI_OFF_RXDATA, v);
		`CHK(v, 8'h5a)
		rd(`SCSI_OFF_STATUS, v);
		`CHK(v, 8'hc4)
		// Card clock: running, then fixed low and high levels, then the port.
		wr(`SCSI_OFF_CTRL, 8'h01);
		repeat (4) @(posedge i_core_clk);
		#1;
		v[0] = o_card_clk;
		`CHK(o_card_clk_oe, 1'b1)
		@(posedge i_core_clk);
		#1;
		`CHK(o_card_clk, ~v[0])
		wr(`SCSI_OFF_MODE, 8'ha8);
		wr(`SCSI_OFF_CTRL, 8'h00);
		repeat (4) @(posedge i_core_clk);
		#1;
		`CHK(o_card_clk, 1'b0)
		`CHK(o_card_clk_oe, 1'b1)
		wr(`SCSI_OFF_CTRL, 8'h02);
		repeat (2) @(posedge i_core_clk);
		#1;
		`CHK(o_card_clk, 1'b1)
		wr(`SCSI_OFF_CTRL, 8'h00);
		wr(`SCSI_OFF_MODE, 8'h28);
		port_mode <= 2'h0;
		repeat (2) @(posedge i_core_clk);
		#1;
		`CHK(o_card_clk_oe, 1'b0)
		finish_test();
	end
endmodule : tb_top
